/* tdma_pkg.sv */
package tdma_pkg;
// What this block does
// - Hold unique 48-bit hardware address, fixed or loaded.
// - Store 160-bit network address from higher layers.
// - Accept singlecast only when addressed to us.
// - One control channel times up to eight channels.
// - Out-of-band: timing taken from continuous frame.
// - Transmit only at indicated, supported rate.
// - Bursts of 512 bits, only in permitted slots.
// - Slot rate 6000, 3000 or 500 per second.
// - Align bursts to time base, apply ranging offset.
// - Slot position referenced to 1 ms markers.
// - Slot numbers come from downstream control channel.
// - Reserved slots used only with own grant.
// - Contention slots use backoff after collisions.
// - Ranging slots carry ranging bursts only.
// - Single-service build may ignore other slot types.
// - Accept and use extra slot grants.
// - Service channel until initialised, then data channel.
// - Single channel carries service and data.
// - Marker with counter keeps terminals synchronised.
// - Singlecast messages use 48-bit hardware address.
// - Control messages on path 0x000, channel 0x0021.

	localparam int unsigned CLK_HZ       = 200_000_000;
	localparam int unsigned MS_PER_S     = 1000;
	localparam int unsigned SYNC_LOSS_MS = 3;
	localparam int unsigned RATE_HI_BPS  = 3_088_000;
	localparam int unsigned RATE_MID_BPS = 1_544_000;
	localparam int unsigned RATE_LO_BPS  = 256_000;
	localparam int unsigned SLOTS_HI     = 6000;
	localparam int unsigned SLOTS_MID    = 3000;
	localparam int unsigned SLOTS_LO     = 500;
	localparam int unsigned BIT_CYC_HI   = CLK_HZ / RATE_HI_BPS;
	localparam int unsigned BIT_CYC_MID  = CLK_HZ / RATE_MID_BPS;
	localparam int unsigned BIT_CYC_LO   = CLK_HZ / RATE_LO_BPS;
	localparam int unsigned SLOT_CYC_HI_DEF   = CLK_HZ / SLOTS_HI;
	localparam int unsigned SLOT_CYC_MID_DEF  = CLK_HZ / SLOTS_MID;
	localparam int unsigned SLOT_CYC_LO_DEF   = CLK_HZ / SLOTS_LO;
	localparam int unsigned SYNC_LOSS_CYC_DEF = CLK_HZ / MS_PER_S * SYNC_LOSS_MS;

	localparam int unsigned BURST_BITS = 512;
	localparam int unsigned UC_W       = 3;
	localparam int unsigned HW_ADDR_W  = 48;
	localparam int unsigned NWK_ADDR_W = 160;
	localparam int unsigned SLOT_W     = 16;
	localparam int unsigned ARG_W      = 32;
	localparam int unsigned OFS_W      = 16;

	localparam logic [11:0] CTRL_VPI = 12'h000;
	localparam logic [15:0] CTRL_VCI = 16'h0021;

	localparam logic [7:0] MSG_PROV      = 8'h01;
	localparam logic [7:0] MSG_DEFCFG    = 8'h02;
	localparam logic [7:0] MSG_RANGE     = 8'h05;
	localparam logic [7:0] MSG_INIT_DONE = 8'h07;
	localparam logic [7:0] MSG_GRANT     = 8'h28;
	localparam logic [7:0] MSG_TX_CTRL   = 8'h40;

	localparam int unsigned ARG_FIRST_LSB  = 0;
	localparam int unsigned ARG_COUNT_LSB  = 16;
	localparam int unsigned ARG_KIND_LSB   = 24;
	localparam int unsigned ARG_OURS_BIT   = 26;
	localparam int unsigned ARG_OFS_LSB    = 0;
	localparam int unsigned ARG_RATE_LSB   = 0;
	localparam int unsigned ARG_PROV_LSB   = 0;
	localparam int unsigned ARG_SVC_LSB    = 0;
	localparam int unsigned ARG_DATA_LSB   = 3;
	localparam int unsigned ARG_SINGLE_BIT = 6;

	localparam logic [UC_W-1:0] SVC_CH_RST  = 3'h0;
	localparam logic [UC_W-1:0] DATA_CH_RST = 3'h1;
	localparam logic [7:0]      PROV_RST    = 8'h00;
	localparam logic [15:0]     LFSR_SEED   = 16'hACE1;

	typedef enum logic [1:0] {
		RATE_LO  = 2'b00,
		RATE_MID = 2'b01,
		RATE_HI  = 2'b10
	} rate_type;

	typedef enum logic [1:0] {
		SLOT_FIXED = 2'b00,
		SLOT_DYN   = 2'b01,
		SLOT_CONT  = 2'b10,
		SLOT_RANGE = 2'b11
	} slot_kind_type;

	typedef struct packed {
		logic                 valid;
		logic [11:0]          vpi;
		logic [15:0]          vci;
		logic                 bcast;
		logic [HW_ADDR_W-1:0] dest;
		logic [7:0]           msg;
		logic [ARG_W-1:0]     arg;
	} dn_cell_type;

	typedef struct packed {
		logic              valid;
		logic [SLOT_W-1:0] count;
	} ds_sync_type;

	typedef struct packed {
		logic              valid;
		logic [SLOT_W-1:0] first;
		logic [7:0]        count;
		slot_kind_type     kind;
		logic              ours;
	} grant_type;
endpackage

/* pin_sync3.sv */
`timescale 1ns/1ps
module pin_sync3 #(
	parameter int unsigned W = 1
)
(
	input  wire logic         mclk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] lvl_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	// Level moves only once the last two stages agree
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			lvl_o <= '0;
		end
		else
		begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_o <= (s2_ff & ~(s2_ff ^ s3_ff)) | (lvl_o & (s2_ff ^ s3_ff));
		end
	end
endmodule

/* burst_shifter.sv */
`timescale 1ns/1ps
module burst_shifter #(
	parameter int unsigned W  = 512,
	parameter int unsigned CW = 16
)
(
	input  wire logic          mclk_i,
	input  wire logic          srst_i,
	input  wire logic          start_i,
	input  wire logic [W-1:0]  data_i,
	input  wire logic [CW-1:0] bit_cyc_i,
	output logic               bit_o,
	output logic               en_o,
	output logic               busy_o
);
	localparam int unsigned LW = $clog2(W + 1);

	logic [W-1:0]  sh_ff;
	logic [CW-1:0] div_ff;
	logic [CW-1:0] per_ff;
	logic [LW-1:0] left_ff;

	assign busy_o = (left_ff != '0);

	// Bit period latched at start so a rate change cannot tear a burst
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			sh_ff   <= '0;
			div_ff  <= '0;
			per_ff  <= '0;
			left_ff <= '0;
			bit_o   <= 1'b0;
			en_o    <= 1'b0;
		end
		else if (start_i && !busy_o)
		begin
			sh_ff   <= data_i;
			per_ff  <= bit_cyc_i;
			div_ff  <= '0;
			left_ff <= LW'(W);
			bit_o   <= data_i[W-1];
			en_o    <= 1'b1;
		end
		else if (busy_o)
		begin
			if (div_ff == per_ff - CW'(1))
			begin
				div_ff  <= '0;
				left_ff <= left_ff - LW'(1);
				sh_ff   <= sh_ff << 1;
				bit_o   <= sh_ff[W-2];
				if (left_ff == LW'(1))
				begin
					en_o  <= 1'b0;
					bit_o <= 1'b0;
				end
			end
			else
			begin
				div_ff <= div_ff + CW'(1);
			end
		end
	end
endmodule

/* upstream_tdma_slot_access.sv */
`timescale 1ns/1ps
module upstream_tdma_slot_access
	import tdma_pkg::*;
#(
	parameter logic [HW_ADDR_W-1:0] HW_ADDR_DEF   = 48'h020000000001, // Arbitrary value
	parameter rate_type             SUPPORTED     = RATE_HI,
	parameter logic [3:0]           SVC_KINDS     = 4'hF,
	parameter int unsigned          GRANTS        = 4,
	parameter int unsigned          BEXP_MAX      = 8,
	parameter int unsigned          SLOT_CYC_HI   = SLOT_CYC_HI_DEF,
	parameter int unsigned          SLOT_CYC_MID  = SLOT_CYC_MID_DEF,
	parameter int unsigned          SLOT_CYC_LO   = SLOT_CYC_LO_DEF,
	parameter int unsigned          SYNC_LOSS_CYC = SYNC_LOSS_CYC_DEF
)
(
	input  wire logic                   mclk_i,
	input  wire logic                   srst_i,
	input  wire logic                   hw_addr_load_i,
	input  wire logic [HW_ADDR_W-1:0]   hw_addr_i,
	input  wire logic                   nwk_addr_wr_i,
	input  wire logic [NWK_ADDR_W-1:0]  nwk_addr_i,
	input  wire logic                   ib_mode_i,
	input  wire logic                   oob_mark_tgl_i,
	input  wire logic                   ib_mark_tgl_i,
	input  wire ds_sync_type            ds_sync_i,
	input  wire dn_cell_type            dn_cell_i,
	input  wire logic                   tx_req_i,
	input  wire logic [BURST_BITS-1:0]  tx_data_i,
	input  wire logic                   tx_ranging_i,
	input  wire logic                   ack_i,
	input  wire logic                   collision_i,
	output logic                        tx_ready_o,
	output logic [HW_ADDR_W-1:0]        hw_addr_o,
	output logic [NWK_ADDR_W-1:0]       nwk_addr_o,
	output dn_cell_type                 rx_cell_o,
	output logic [SLOT_W-1:0]           slot_num_o,
	output logic                        slot_start_o,
	output logic                        marker_o,
	output logic                        sync_ok_o,
	output logic                        rate_ok_o,
	output logic                        tx_bit_o,
	output logic                        tx_en_o,
	output slot_kind_type               tx_kind_o,
	output logic [UC_W-1:0]             tx_ch_o,
	output logic [7:0]                  prov_freq_o,
	output logic                        init_done_o
);
	localparam int unsigned GI_W = $clog2(GRANTS);

	logic [1:0]            mark_lvl;
	logic [1:0]            mark_prev_ff;
	logic                  mark_evt;
	logic                  marker_ff;
	logic [HW_ADDR_W-1:0]  hw_addr_ff;
	logic [NWK_ADDR_W-1:0] nwk_addr_ff;
	dn_cell_type           rx_cell_ff;
	logic                  ctl_vc;
	logic                  for_us;
	logic                  cell_acc;
	logic [ARG_W-1:0]      arg;
	rate_type              rate_ff;
	logic                  rate_vld_ff;
	logic                  rate_ok_ff;
	logic [OFS_W-1:0]      ofs_ff;
	logic [7:0]            prov_ff;
	logic [UC_W-1:0]       svc_ch_ff;
	logic [UC_W-1:0]       data_ch_ff;
	logic                  single_ff;
	logic                  init_done_ff;
	logic [UC_W-1:0]       tx_ch_ff;
	logic [31:0]           period;
	logic [15:0]           bit_cyc;
	logic                  sync_pend_ff;
	logic [SLOT_W-1:0]     sync_cnt_ff;
	logic                  reload;
	logic [SLOT_W-1:0]     reload_val;
	logic [31:0]           tmr_ff;
	logic [SLOT_W-1:0]     slot_cnt_ff;
	logic                  slot_start_ff;
	logic [31:0]           loss_ff;
	logic                  sync_ok_ff;
	logic [31:0]           adv_pt;
	logic                  adv_evt;
	logic [SLOT_W-1:0]     nxt_slot;
	logic [SLOT_W-1:0]     dlt;
	grant_type             tbl_ff [GRANTS];
	logic                  hit;
	logic [GI_W-1:0]       hit_idx;
	slot_kind_type         hit_kind;
	logic                  hit_ours;
	logic                  hit_last;
	logic                  free_ok;
	logic [GI_W-1:0]       free_idx;
	logic                  go;
	logic                  fire;
	logic                  cont_tick;
	logic                  busy;
	logic                  hold_ff;
	logic                  hold_rng_ff;
	logic                  wait_ff;
	logic [BURST_BITS-1:0] data_ff;
	logic [3:0]            bexp_ff;
	logic [3:0]            nbexp;
	logic [7:0]            backoff_ff;
	logic [15:0]           lfsr_ff;
	slot_kind_type         tx_kind_ff;

	assign hw_addr_o    = hw_addr_ff;
	assign nwk_addr_o   = nwk_addr_ff;
	assign rx_cell_o    = rx_cell_ff;
	assign slot_num_o   = slot_cnt_ff;
	assign slot_start_o = slot_start_ff;
	assign marker_o     = marker_ff;
	assign sync_ok_o    = sync_ok_ff;
	assign rate_ok_o    = rate_ok_ff;
	assign tx_kind_o    = tx_kind_ff;
	assign tx_ch_o      = tx_ch_ff;
	assign prov_freq_o  = prov_ff;
	assign init_done_o  = init_done_ff;
	assign tx_ready_o   = !hold_ff;

	// Marker toggles come from the receiver front end, another clock
	pin_sync3 #(
		.W(2)
	) u_mark_sync (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.pin_i ({ib_mark_tgl_i, oob_mark_tgl_i}),
		.lvl_o (mark_lvl)
	);

	assign mark_evt = ib_mode_i ? (mark_lvl[1] ^ mark_prev_ff[1])
	                            : (mark_lvl[0] ^ mark_prev_ff[0]);

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			mark_prev_ff <= '0;
			marker_ff    <= 1'b0;
		end
		else
		begin
			mark_prev_ff <= mark_lvl;
			marker_ff    <= mark_evt;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			hw_addr_ff  <= HW_ADDR_DEF;
			nwk_addr_ff <= '0;
		end
		else
		begin
			if (hw_addr_load_i)
				hw_addr_ff <= hw_addr_i;
			if (nwk_addr_wr_i)
				nwk_addr_ff <= nwk_addr_i;
		end
	end

	assign ctl_vc   = dn_cell_i.valid && dn_cell_i.vpi == CTRL_VPI
	                  && dn_cell_i.vci == CTRL_VCI;
	assign for_us   = dn_cell_i.bcast || dn_cell_i.dest == hw_addr_ff;
	assign cell_acc = ctl_vc && for_us;
	assign arg      = dn_cell_i.arg;

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			rx_cell_ff <= '0;
		else
		begin
			rx_cell_ff       <= dn_cell_i;
			rx_cell_ff.valid <= cell_acc;
		end
	end

	// Head-end configuration carried in accepted control cells
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			rate_ff      <= RATE_LO;
			rate_vld_ff  <= 1'b0;
			ofs_ff       <= '0;
			prov_ff      <= PROV_RST;
			svc_ch_ff    <= SVC_CH_RST;
			data_ch_ff   <= DATA_CH_RST;
			single_ff    <= 1'b0;
			init_done_ff <= 1'b0;
		end
		else if (cell_acc)
		begin
			unique case (dn_cell_i.msg)
				MSG_TX_CTRL:
				begin
					rate_ff     <= rate_type'(arg[ARG_RATE_LSB +: 2]);
					rate_vld_ff <= 1'b1;
				end
				MSG_RANGE:
					ofs_ff <= arg[ARG_OFS_LSB +: OFS_W];
				MSG_PROV:
					prov_ff <= arg[ARG_PROV_LSB +: 8];
				MSG_DEFCFG:
				begin
					svc_ch_ff  <= arg[ARG_SVC_LSB +: UC_W];
					data_ch_ff <= arg[ARG_DATA_LSB +: UC_W];
					single_ff  <= arg[ARG_SINGLE_BIT];
				end
				MSG_INIT_DONE:
					init_done_ff <= 1'b1;
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			rate_ok_ff <= 1'b0;
			tx_ch_ff   <= SVC_CH_RST;
		end
		else
		begin
			rate_ok_ff <= rate_vld_ff && rate_ff == SUPPORTED;
			// Up to eight channels share this control channel's timing
			tx_ch_ff <= (single_ff || !init_done_ff) ? svc_ch_ff
			                                         : data_ch_ff;
		end
	end

	always_comb
	begin
		unique case (rate_ff)
			RATE_HI:
			begin
				period  = 32'(SLOT_CYC_HI);
				bit_cyc = 16'(BIT_CYC_HI);
			end
			RATE_MID:
			begin
				period  = 32'(SLOT_CYC_MID);
				bit_cyc = 16'(BIT_CYC_MID);
			end
			RATE_LO:
			begin
				period  = 32'(SLOT_CYC_LO);
				bit_cyc = 16'(BIT_CYC_LO);
			end
			default:
			begin
				period  = 32'(SLOT_CYC_LO);
				bit_cyc = 16'(BIT_CYC_LO);
			end
		endcase
	end

	// Counter value arrives ahead of its marker and waits for it
	assign reload     = mark_evt && (sync_pend_ff || ds_sync_i.valid);
	assign reload_val = ds_sync_i.valid ? ds_sync_i.count : sync_cnt_ff;

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			sync_pend_ff <= 1'b0;
			sync_cnt_ff  <= '0;
		end
		else if (mark_evt)
			sync_pend_ff <= 1'b0;
		else if (ds_sync_i.valid)
		begin
			sync_pend_ff <= 1'b1;
			sync_cnt_ff  <= ds_sync_i.count;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			tmr_ff        <= '0;
			slot_cnt_ff   <= '0;
			slot_start_ff <= 1'b0;
		end
		else if (reload)
		begin
			tmr_ff        <= '0;
			slot_cnt_ff   <= reload_val;
			slot_start_ff <= 1'b1;
		end
		else if (tmr_ff >= period - 32'h1)
		begin
			tmr_ff        <= '0;
			slot_cnt_ff   <= slot_cnt_ff + SLOT_W'(1);
			slot_start_ff <= 1'b1;
		end
		else
		begin
			tmr_ff        <= tmr_ff + 32'h1;
			slot_start_ff <= 1'b0;
		end
	end

	// Without fresh markers the slot grid drifts, so transmit stops
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			loss_ff    <= '0;
			sync_ok_ff <= 1'b0;
		end
		else if (reload)
		begin
			loss_ff    <= '0;
			sync_ok_ff <= 1'b1;
		end
		else
		begin
			if (loss_ff != 32'(SYNC_LOSS_CYC))
				loss_ff <= loss_ff + 32'h1;
			if (loss_ff == 32'(SYNC_LOSS_CYC - 1))
				sync_ok_ff <= 1'b0;
		end
	end

	// Burst leaves early by the ranged delay so it lands on the slot
	assign adv_pt   = ({16'h0000, ofs_ff} >= period) ? 32'h0
	                  : period - 32'h1 - {16'h0000, ofs_ff};
	assign adv_evt  = sync_ok_ff && !reload && tmr_ff == adv_pt;
	assign nxt_slot = slot_cnt_ff + SLOT_W'(1);

	always_comb
	begin
		dlt      = '0;
		hit      = 1'b0;
		hit_idx  = '0;
		hit_kind = SLOT_CONT;
		hit_ours = 1'b0;
		hit_last = 1'b0;
		free_ok  = 1'b0;
		free_idx = '0;
		for (int i = GRANTS - 1; i >= 0; i--)
		begin
			dlt = nxt_slot - tbl_ff[i].first;
			if (tbl_ff[i].valid && dlt < {8'h00, tbl_ff[i].count})
			begin
				hit      = 1'b1;
				hit_idx  = GI_W'(i);
				hit_kind = tbl_ff[i].kind;
				hit_ours = tbl_ff[i].ours;
				hit_last = dlt == {8'h00, tbl_ff[i].count} - SLOT_W'(1);
			end
			if (!tbl_ff[i].valid)
			begin
				free_ok  = 1'b1;
				free_idx = GI_W'(i);
			end
		end
	end

	// Full table drops further grants rather than evict a live one
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			for (int i = 0; i < GRANTS; i++)
				tbl_ff[i] <= '0;
		end
		else
		begin
			if (adv_evt && hit && hit_last && hit_kind != SLOT_FIXED)
				tbl_ff[hit_idx].valid <= 1'b0;
			if (cell_acc && dn_cell_i.msg == MSG_GRANT)
			begin
				if (arg[ARG_COUNT_LSB +: 8] == 8'h00)
				begin
					for (int i = 0; i < GRANTS; i++)
						if (tbl_ff[i].first == arg[ARG_FIRST_LSB +: SLOT_W])
							tbl_ff[i].valid <= 1'b0;
				end
				else if (free_ok)
				begin
					tbl_ff[free_idx].valid <= 1'b1;
					tbl_ff[free_idx].first <= arg[ARG_FIRST_LSB +: SLOT_W];
					tbl_ff[free_idx].count <= arg[ARG_COUNT_LSB +: 8];
					tbl_ff[free_idx].kind  <= slot_kind_type'(arg[ARG_KIND_LSB +: 2]);
					tbl_ff[free_idx].ours  <= !dn_cell_i.bcast || arg[ARG_OURS_BIT];
				end
			end
		end
	end

	always_comb
	begin
		go = 1'b0;
		unique case (hit_kind)
			SLOT_FIXED, SLOT_DYN:
				go = hit_ours && !hold_rng_ff;
			SLOT_CONT:
				go = !hold_rng_ff && backoff_ff == 8'h00 && !wait_ff;
			SLOT_RANGE:
				go = hold_rng_ff;
		endcase
	end

	assign fire      = adv_evt && hit && SVC_KINDS[hit_kind] && hold_ff
	                   && rate_ok_ff && !busy && go;
	assign cont_tick = adv_evt && hit && SVC_KINDS[hit_kind]
	                   && hit_kind == SLOT_CONT && !wait_ff && backoff_ff != 8'h00;
	assign nbexp     = (bexp_ff == 4'(BEXP_MAX)) ? bexp_ff : bexp_ff + 4'h1;

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			lfsr_ff <= LFSR_SEED;
		else
			lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
	end

	// Contention burst is held for resend until acknowledged
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			hold_ff     <= 1'b0;
			hold_rng_ff <= 1'b0;
			wait_ff     <= 1'b0;
			data_ff     <= '0;
			bexp_ff     <= '0;
			backoff_ff  <= '0;
			tx_kind_ff  <= SLOT_CONT;
		end
		else
		begin
			if (tx_req_i && !hold_ff)
			begin
				hold_ff     <= 1'b1;
				hold_rng_ff <= tx_ranging_i;
				data_ff     <= tx_data_i;
			end
			if (fire)
			begin
				tx_kind_ff <= hit_kind;
				if (hit_kind == SLOT_CONT)
					wait_ff <= 1'b1;
				else
					hold_ff <= 1'b0;
			end
			if (cont_tick)
				backoff_ff <= backoff_ff - 8'h01;
			if (wait_ff && ack_i)
			begin
				wait_ff <= 1'b0;
				hold_ff <= 1'b0;
				bexp_ff <= '0;
			end
			else if (wait_ff && collision_i)
			begin
				wait_ff    <= 1'b0;
				bexp_ff    <= nbexp;
				backoff_ff <= lfsr_ff[7:0] & 8'((9'h001 << nbexp) - 9'h001);
			end
		end
	end

	burst_shifter #(
		.W (BURST_BITS),
		.CW(16)
	) u_tx (
		.mclk_i   (mclk_i),
		.srst_i   (srst_i),
		.start_i  (fire),
		.data_i   (data_ff),
		.bit_cyc_i(bit_cyc),
		.bit_o    (tx_bit_o),
		.en_o     (tx_en_o),
		.busy_o   (busy)
	);
endmodule

/* upstream_tdma_slot_access_monitor.sv */
`timescale 1ns/1ps
module upstream_tdma_slot_access_monitor
	import tdma_pkg::*;
(
	input wire logic                  mclk_i,
	input wire logic                  srst_i,
	input wire logic                  hw_addr_load_i,
	input wire logic [HW_ADDR_W-1:0]  hw_addr_i,
	input wire logic                  nwk_addr_wr_i,
	input wire logic [NWK_ADDR_W-1:0] nwk_addr_i,
	input wire dn_cell_type           dn_cell_i,
	input wire logic                  tx_req_i,
	input wire logic                  tx_ready_o,
	input wire logic [HW_ADDR_W-1:0]  hw_addr_o,
	input wire logic [NWK_ADDR_W-1:0] nwk_addr_o,
	input wire dn_cell_type           rx_cell_o,
	input wire logic                  slot_start_o,
	input wire logic                  marker_o,
	input wire logic                  sync_ok_o,
	input wire logic                  rate_ok_o,
	input wire logic                  tx_en_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	chk_cell_taken: assert property (dn_cell_i.valid && dn_cell_i.vpi == CTRL_VPI
		&& dn_cell_i.vci == CTRL_VCI && (dn_cell_i.bcast || dn_cell_i.dest == hw_addr_o)
		|=> rx_cell_o.valid) else $error("accepted cell not delivered");
	chk_vc_refused: assert property (dn_cell_i.valid && dn_cell_i.vci != CTRL_VCI
		|=> !rx_cell_o.valid) else $error("cell on foreign channel delivered");
	chk_foreign_dest: assert property (dn_cell_i.valid && !dn_cell_i.bcast
		&& dn_cell_i.dest != hw_addr_o |=> !rx_cell_o.valid) else $error("foreign cell taken");
	chk_hw_addr_load: assert property (hw_addr_load_i |=> hw_addr_o == $past(hw_addr_i))
		else $error("hardware address not loaded");
	chk_nwk_addr_store: assert property (nwk_addr_wr_i |=> nwk_addr_o == $past(nwk_addr_i))
		else $error("network address not stored");
	chk_req_taken: assert property (tx_req_i && tx_ready_o |=> !tx_ready_o)
		else $error("burst request not held");
	chk_burst_gate: assert property ($rose(tx_en_o) |-> sync_ok_o && rate_ok_o)
		else $error("burst without sync or rate");
	chk_burst_hold: assert property ($rose(tx_en_o) |-> tx_en_o [*8])
		else $error("burst cut short");
	chk_slot_pulse: assert property (slot_start_o |=> !slot_start_o)
		else $error("slot start longer than one cycle");
	chk_sync_reload: assert property ($rose(sync_ok_o) |-> slot_start_o && marker_o)
		else $error("sync gained without marker reload");
endmodule
bind upstream_tdma_slot_access upstream_tdma_slot_access_monitor chk (.mclk_i, .srst_i,
	.hw_addr_load_i, .hw_addr_i, .nwk_addr_wr_i, .nwk_addr_i, .dn_cell_i, .tx_req_i,
	.tx_ready_o, .hw_addr_o, .nwk_addr_o, .rx_cell_o, .slot_start_o, .marker_o,
	.sync_ok_o, .rate_ok_o, .tx_en_o);

/* headend_model.sv */
`timescale 1ns/1ps
module headend_model
	import tdma_pkg::*;
(
	input  wire logic mclk_i,
	output logic      mark_tgl_o,
	output ds_sync_type sync_o,
	output dn_cell_type cell_o,
	output logic      ack_o,
	output logic      collision_o
);
	localparam int MARK_CYC = 1000;
	logic [SLOT_W-1:0] cnt_ff = 16'h0010;
	logic [SLOT_W-1:0] last_cnt = 16'h0000;
	logic              run = 1'b0;
	int                tick = 0;
	initial
	begin
		mark_tgl_o = 1'b0;
		sync_o = '0;
		cell_o = '0;
		ack_o = 1'b0;
		collision_o = 1'b0;
	end
	// Counter sent shortly before each marker, ten slots per marker
	// Marker spacing must be exactly ten slots or reload lands off the grid
	always @(posedge mclk_i)
	begin
		if (run)
		begin
			tick <= (tick == MARK_CYC - 1) ? 0 : tick + 1;
			sync_o <= {tick == MARK_CYC - 8, cnt_ff};
			if (tick == MARK_CYC - 8)
				last_cnt <= cnt_ff;
			if (tick == MARK_CYC - 1)
			begin
				mark_tgl_o <= ~mark_tgl_o;
				cnt_ff <= cnt_ff + 16'h000A;
			end
		end
	end
	task automatic send_cell(input logic [15:0] vci, input logic [47:0] dest, input logic bc,
		input logic [7:0] msg, input logic [31:0] arg);
		@(posedge mclk_i);
		cell_o <= {1'b1, CTRL_VPI, vci, bc, dest, msg, arg};
		@(posedge mclk_i);
		// Released fields flip so stale data cannot pass for a cell
		cell_o <= {1'b0, ~cell_o[$bits(dn_cell_type)-2:0]};
	endtask
endmodule

/* upstream_tdma_slot_access_bench.sv */
`timescale 1ns/1ps
module upstream_tdma_slot_access_bench;
	import tdma_pkg::*;
	localparam logic [47:0] MY_ADDR = 48'h0A0B0C0D0E0F;
	localparam logic [511:0] BURST = {16{32'hA5C30F1E}};
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic hw_addr_load_i = 1'b0;
	logic [47:0] hw_addr_i = 48'h0;
	logic nwk_addr_wr_i = 1'b0;
	logic [159:0] nwk_addr_i = 160'h0;
	logic tx_req_i = 1'b0;
	logic [511:0] tx_data_i = BURST;
	logic oob_mark_tgl_i, ack_i, collision_i;
	ds_sync_type ds_sync_i;
	dn_cell_type dn_cell_i, rx_cell_o;
	slot_kind_type tx_kind_o;
	logic tx_ready_o, marker_o, slot_start_o, sync_ok_o, rate_ok_o, tx_bit_o, tx_en_o;
	logic init_done_o;
	logic [47:0] hw_addr_o;
	logic [159:0] nwk_addr_o;
	logic [15:0] slot_num_o;
	logic [2:0] tx_ch_o;
	logic [7:0] prov_freq_o;
	int num_errors = 0;
	int num_checks = 0;
	always #2.5 mclk_i = ~mclk_i;
	upstream_tdma_slot_access #(.SLOT_CYC_HI(100), .SYNC_LOSS_CYC(3000)) dut (.mclk_i, .srst_i,
		.hw_addr_load_i, .hw_addr_i, .nwk_addr_wr_i, .nwk_addr_i, .ib_mode_i(1'b0),
		.oob_mark_tgl_i, .ib_mark_tgl_i(1'b0), .ds_sync_i, .dn_cell_i, .tx_req_i, .tx_data_i,
		.tx_ranging_i(1'b0), .ack_i, .collision_i, .tx_ready_o, .hw_addr_o, .nwk_addr_o,
		.rx_cell_o, .slot_num_o, .slot_start_o, .marker_o, .sync_ok_o, .rate_ok_o, .tx_bit_o,
		.tx_en_o, .tx_kind_o, .tx_ch_o, .prov_freq_o, .init_done_o);
	headend_model he (.mclk_i, .mark_tgl_o(oob_mark_tgl_i), .sync_o(ds_sync_i),
		.cell_o(dn_cell_i), .ack_o(ack_i), .collision_o(collision_i));
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [159:0] got, input logic [159:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// Bounded wait on slot start (0), marker (1) or burst enable (2)
	task automatic wait_hi(input int sel, input int lim);
		int n;
		n = 0;
		while (n < lim && ((sel == 0) ? slot_start_o : (sel == 1) ? marker_o : tx_en_o) !== 1'b1)
		begin
			step(1);
			n++;
		end
		if (n >= lim)
		begin
			check(1'b0, 1'b1);
			complete_run();
		end
	endtask
	task automatic t_reset();
		check(hw_addr_o, 48'h020000000001);
		check({tx_ready_o, sync_ok_o, init_done_o, tx_kind_o, tx_ch_o}, 8'h90);
		$display("Test reset done");
	endtask
	task automatic t_addr();
		@(posedge mclk_i);
		hw_addr_load_i <= 1'b1;
		hw_addr_i <= MY_ADDR;
		nwk_addr_wr_i <= 1'b1;
		nwk_addr_i <= {5{32'h1234ABCD}};
		@(posedge mclk_i);
		hw_addr_load_i <= 1'b0;
		nwk_addr_wr_i <= 1'b0;
		#1;
		check(hw_addr_o, MY_ADDR);
		check(nwk_addr_o, {5{32'h1234ABCD}});
		$display("Test addresses done");
	endtask
	task automatic t_cells();
		he.send_cell(CTRL_VCI, 48'h1, 1'b0, MSG_PROV, 32'h33);
		#1;
		check({rx_cell_o.valid, prov_freq_o}, 9'h000);
		he.send_cell(16'h0022, MY_ADDR, 1'b1, MSG_PROV, 32'h33);
		#1;
		check({rx_cell_o.valid, prov_freq_o}, 9'h000);
		he.send_cell(CTRL_VCI, MY_ADDR, 1'b0, MSG_PROV, 32'h5A);
		#1;
		check({rx_cell_o.valid, prov_freq_o}, 9'h15A);
		he.send_cell(CTRL_VCI, 48'h0, 1'b1, MSG_DEFCFG, 32'h22);
		step(1);
		check(tx_ch_o, 3'h2);
		he.send_cell(CTRL_VCI, MY_ADDR, 1'b0, MSG_INIT_DONE, 32'h0);
		step(1);
		check({init_done_o, tx_ch_o}, 4'hC);
		$display("Test cells done");
	endtask
	task automatic t_sync();
		int n;
		// Rate first: slot period follows the selected rate
		he.send_cell(CTRL_VCI, MY_ADDR, 1'b0, MSG_TX_CTRL, 32'h2);
		step(1);
		check(rate_ok_o, 1'b1);
		he.run = 1'b1;
		wait_hi(1, 2000);
		check({slot_num_o, slot_start_o, sync_ok_o}, {he.last_cnt, 2'b11});
		n = 0;
		step(1);
		while (slot_start_o !== 1'b1 && n < 200)
		begin
			step(1);
			n++;
		end
		check(n, 99);
		check(slot_num_o, he.last_cnt + 16'h1);
		$display("Test sync done");
	endtask
	task automatic t_burst();
		int n;
		logic [15:0] g;
		g = slot_num_o + 16'h4;
		he.send_cell(CTRL_VCI, 48'h0, 1'b1, MSG_GRANT, {8'h00, 8'h01, g - 16'h2});
		he.send_cell(CTRL_VCI, MY_ADDR, 1'b0, MSG_GRANT, {8'h04, 8'h01, g});
		@(posedge mclk_i);
		tx_req_i <= 1'b1;
		@(posedge mclk_i);
		tx_req_i <= 1'b0;
		#1;
		check(tx_ready_o, 1'b0);
		wait_hi(2, 1000);
		check(slot_num_o == g || slot_num_o == g - 16'h1, 1'b1);
		check({tx_bit_o, tx_kind_o}, {BURST[511], SLOT_FIXED});
		step(64);
		check(tx_bit_o, BURST[510]);
		n = 64;
		while (tx_en_o === 1'b1 && n < 40000)
		begin
			step(1);
			n++;
		end
		check(n, 512 * 64);
		check({tx_ready_o, sync_ok_o}, 2'b11);
		$display("Test burst done");
	endtask
	initial
	begin
		step(2);
		srst_i <= 1'b0;
		step(1);
		t_reset();
		t_addr();
		t_cells();
		t_sync();
		t_burst();
		complete_run();
	end
endmodule
